// [rtl/xdgf_framer.sv]
// Purpose: builds length-indicator, data-carrying and label segment groups
// Assumes: requests and payload come from logic on ref_clk
// Notes:   one group at a time; no interleaving of other applications

`timescale 1ns/100ps

// ==========================================
// payload buffer
module xdgf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             wr;
  logic             rd;

  assign wr_ready = cnt_q != (AW+1)'(DEPTH);
  assign rd_valid = cnt_q != '0;
  assign rd_data  = mem_q[rp_q];
  assign wr       = wr_valid & wr_ready;
  assign rd       = rd_valid & rd_ready;

  always_ff @(posedge clk) begin
    if (wr) begin
      mem_q[wp_q] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (wr) begin
        wp_q <= wp_q + 1'b1;
      end
      if (rd) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule

// Functional notes
// - check word is 16-bit code, generator x^16 + x^12 + x^5 + 1
// - every bit of the check word is inverted before sending
// - check register preset to all ones at each group start
// - zero filler bytes after check word up to sub-field end
// - each data-carrying job is a length group then the data group
// - length group uses application type 1
// - top two bits of the length word are zero
// - bits 13..0 hold byte count of the following data group
// - length group check word covers only its first word
// - one whole data group goes unsplit into the second group
// - short format frame n: type 1 indicator plus three length bytes
// - short format frame n+1: fourth length byte plus three zeros
// - short format frame n+2: start-type indicator plus three data bytes
// - later frames may interleave other applications and resume
// - variable format: length and data sub-fields adjacent
// - label message at most 128 bytes of characters
// - label split into at most 8 segments of up to 16 bytes
// - each label segment in its own group
// - whole message sent before any command for it
// - segment layout: toggle, first/last, command flag, control, data, check
// - toggle held within a message or command, inverted on a new one
// - first/last codes: 00 middle, 01 last, 10 first, 11 sole
// - message control: length minus one, charset or segment index
// - command control: code in 11..8, clear display has no data
module xdgf_framer (
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  input  wire logic [7:0]         in_data,
  input  wire logic               in_valid,
  output logic                    in_ready,
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire xdgf_pkg::xdgf_kind_t req_kind,
  input  wire logic [13:0]        req_len,
  input  wire logic [4:0]         application_type_code,
  input  wire logic [3:0]         req_charset,
  input  wire logic [3:0]         req_cmd,
  input  wire logic               req_repeat,
  input  wire logic               short_mode,
  input  wire logic [2:0]         sf_len_code,
  output logic [7:0]              xp_data,
  output logic                    xp_valid,
  input  wire logic               xp_ready,
  output logic                    xp_ci,
  output logic                    xp_sf_last,
  output logic                    busy
);
  import xdgf_pkg::*;

  // ==========================================
  // helpers
  // msb first into the register
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ b[i]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [5:0] sf_bytes(input logic [2:0] code);
    logic [5:0] r;
    unique case (code)
      3'h0: r = 6'h04;
      3'h1: r = 6'h06;
      3'h2: r = 6'h08;
      3'h3: r = 6'h0C;
      3'h4: r = 6'h10;
      3'h5: r = 6'h18;
      3'h6: r = 6'h20;
      3'h7: r = 6'h30;
    endcase
    return r;
  endfunction

  // at most 16 bytes per segment
  function automatic logic [4:0] seg_len(input logic [7:0] rem);
    return (rem > 8'(SEG_MAX_BYTES)) ? SEG_MAX_BYTES : rem[4:0];
  endfunction

  function automatic logic [15:0] dl_hdr(input logic tog, input logic first, input logic last,
                                         input logic [4:0] len, input logic [3:0] f2);
    return {tog, first, last, 1'b0, 4'(len - 5'h01), f2, RFA4};
  endfunction

  // ==========================================
  // state
  xdgf_state_t st_q;
  xdgf_state_t ret_q;
  xdgf_state_t nb;
  xdgf_kind_t  kind_q;
  logic        grp_q;
  logic [2:0]  seg_q;
  logic [3:0]  nseg_q;
  logic [13:0] left_q;
  logic [7:0]  rem_q;
  logic [7:0]  dl_len_q;
  logic [5:0]  sf_left_q;
  logic [15:0] crc_q;
  logic [15:0] hdr_q;
  logic        bi_q;
  logic        has_crc_q;
  logic        cont_q;
  logic [4:0]  app_q;
  logic [13:0] msc_len_q;
  logic        short_q;
  logic [2:0]  code_q;
  logic        msg_tog_q;
  logic        cmd_tog_q;
  logic [7:0]  out_q;
  logic        ov_q;
  logic        ci_q;
  logic        sfl_q;

  logic [7:0]  fifo_data;
  logic        fifo_valid;
  logic        gen_valid;
  logic [7:0]  gen_byte;
  logic        g_end;
  logic        adv;
  logic        start_job;
  logic        gdone;
  logic        body;
  logic [5:0]  reload;
  logic [4:0]  ci_app;
  logic [7:0]  req_dl_len;
  logic [4:0]  req_s0;
  logic        msg_tog_n;
  logic        cmd_tog_n;
  logic [4:0]  nxt_len;

  xdgf_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (ref_clk),
    .rst      (sys_rst),
    .wr_data  (in_data),
    .wr_valid (in_valid),
    .wr_ready (in_ready),
    .rd_data  (fifo_data),
    .rd_valid (fifo_valid),
    .rd_ready (adv && st_q == S_DATA)
  );

  // ==========================================
  // request side
  // requests only taken when idle, so a command follows its message
  assign req_ready  = st_q == S_IDLE;
  assign start_job  = req_valid & req_ready;
  assign busy       = (st_q != S_IDLE) | ov_q;
  assign req_dl_len = (req_len == 14'h0) ? 8'h01 :
                      (req_len > 14'(DL_MAX_BYTES)) ? DL_MAX_BYTES : req_len[7:0];
  assign req_s0     = seg_len(req_dl_len);
  // new message or command flips its own toggle
  assign msg_tog_n  = req_repeat ? msg_tog_q : ~msg_tog_q;
  assign cmd_tog_n  = req_repeat ? cmd_tog_q : ~cmd_tog_q;
  assign reload     = short_q ? SHORT_SF_BYTES : sf_bytes(code_q);
  assign nxt_len    = seg_len(rem_q);

  // start type per group, continuation is start plus one
  always_comb begin
    if (kind_q == KIND_MSC) begin
      ci_app = grp_q ? app_q : APP_LEN_IND;
    end else begin
      ci_app = APP_DL_START;
    end
    if (cont_q) begin
      ci_app = ci_app + 5'h01;
    end
  end

  // ==========================================
  // byte generator
  always_comb begin
    gen_valid = 1'b1;
    gen_byte  = 8'h00;
    nb        = st_q;
    g_end     = 1'b0;
    unique case (st_q)
      S_IDLE: gen_valid = 1'b0;
      S_CI:   gen_byte  = {short_q ? 3'h0 : code_q, ci_app};
      S_HDR: begin
        gen_byte = bi_q ? hdr_q[7:0] : hdr_q[15:8];
        if (bi_q) begin
          if (left_q != 14'h0) begin
            nb = S_DATA;
          end else if (has_crc_q) begin
            nb = S_CRC;
          end else begin
            g_end = 1'b1;
          end
        end
      end
      S_DATA: begin
        gen_valid = fifo_valid;
        gen_byte  = fifo_data;
        if (left_q == 14'h1) begin
          nb    = has_crc_q ? S_CRC : S_DATA;
          g_end = ~has_crc_q;
        end
      end
      // inverted check word, high byte first
      S_CRC: begin
        gen_byte = bi_q ? ~crc_q[7:0] : ~crc_q[15:8];
        g_end    = bi_q;
      end
      S_PAD:  gen_byte = 8'h00;
    endcase
  end

  assign adv   = gen_valid & (~ov_q | xp_ready);
  assign body  = (st_q == S_HDR) | (st_q == S_DATA) | (st_q == S_CRC);
  assign gdone = adv & (sf_left_q == 6'h01) & ((st_q == S_PAD) | (body & g_end));

  // ==========================================
  // output stage
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ov_q  <= 1'b0;
      out_q <= 8'h00;
      ci_q  <= 1'b0;
      sfl_q <= 1'b0;
    end else if (adv) begin
      ov_q  <= 1'b1;
      out_q <= gen_byte;
      ci_q  <= st_q == S_CI;
      sfl_q <= (st_q != S_CI) && (sf_left_q == 6'h01);
    end else if (xp_ready) begin
      ov_q  <= 1'b0;
    end
  end

  assign xp_data    = out_q;
  assign xp_valid   = ov_q;
  assign xp_ci      = ci_q;
  assign xp_sf_last = sfl_q;

  // ==========================================
  // toggles
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      msg_tog_q <= 1'b0;
      cmd_tog_q <= 1'b0;
    end else if (start_job) begin
      // tracked apart for messages and commands
      if (req_kind == KIND_DL_MSG) begin
        msg_tog_q <= msg_tog_n;
      end
      if (req_kind == KIND_DL_CMD) begin
        cmd_tog_q <= cmd_tog_n;
      end
    end
  end

  // ==========================================
  // group sequencer
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q      <= S_IDLE;
      ret_q     <= S_IDLE;
      kind_q    <= KIND_MSC;
      grp_q     <= 1'b0;
      seg_q     <= 3'h0;
      nseg_q    <= 4'h0;
      left_q    <= 14'h0;
      rem_q     <= 8'h00;
      dl_len_q  <= 8'h00;
      sf_left_q <= 6'h00;
      crc_q     <= CRC_PRESET;
      hdr_q     <= 16'h0000;
      bi_q      <= 1'b0;
      has_crc_q <= 1'b0;
      cont_q    <= 1'b0;
      app_q     <= 5'h00;
      msc_len_q <= 14'h0;
      short_q   <= 1'b0;
      code_q    <= 3'h0;
    end else if (start_job) begin
      kind_q    <= req_kind;
      short_q   <= short_mode;
      code_q    <= sf_len_code;
      app_q     <= application_type_code;
      grp_q     <= 1'b0;
      seg_q     <= 3'h0;
      has_crc_q <= 1'b1;
      ret_q     <= S_HDR;
      st_q      <= S_CI;
      cont_q    <= 1'b0;
      sf_left_q <= short_mode ? SHORT_SF_BYTES : sf_bytes(sf_len_code);
      crc_q     <= CRC_PRESET;
      unique case (req_kind)
        // length word only, then its check
        KIND_MSC: begin
          hdr_q     <= {LI_RFA, req_len};
          left_q    <= 14'h0;
          msc_len_q <= req_len;
        end
        KIND_DL_MSG: begin
          hdr_q    <= dl_hdr(msg_tog_n, 1'b1, req_dl_len <= 8'(SEG_MAX_BYTES), req_s0, req_charset);
          left_q   <= 14'(req_s0);
          rem_q    <= req_dl_len - 8'(req_s0);
          dl_len_q <= req_dl_len;
          nseg_q   <= 4'((req_dl_len + 8'h0F) >> 4);
        end
        // command word, reserved fields zero, no data
        KIND_DL_CMD: begin
          hdr_q  <= {cmd_tog_n, 2'b11, 1'b1, req_cmd, RFA4, RFA4};
          left_q <= 14'h0;
        end
        default: st_q <= S_IDLE;
      endcase
    end else if (adv) begin
      unique case (st_q)
        // short format counts the indicator inside its four bytes
        S_CI: begin
          st_q <= ret_q;
          if (short_q) begin
            sf_left_q <= sf_left_q - 6'h01;
          end
        end
        S_HDR, S_DATA, S_CRC: begin
          if (st_q != S_DATA) begin
            bi_q <= ~bi_q;
          end
          // check runs over header and data only
          if (st_q != S_CRC) begin
            crc_q <= crc_byte(crc_q, gen_byte);
          end
          if (st_q == S_DATA) begin
            left_q <= left_q - 14'h1;
          end
          if (g_end) begin
            // rest of the sub-field filled with zeros
            st_q      <= S_PAD;
            sf_left_q <= sf_left_q - 6'h01;
          end else if (sf_left_q == 6'h01) begin
            // group continues unsplit into the next sub-field
            // resumed at once, nothing else interleaved
            sf_left_q <= reload;
            if (short_q) begin
              st_q <= nb;
            end else begin
              st_q   <= S_CI;
              ret_q  <= nb;
              cont_q <= 1'b1;
            end
          end else begin
            st_q      <= nb;
            sf_left_q <= sf_left_q - 6'h01;
          end
        end
        S_PAD: sf_left_q <= sf_left_q - 6'h01;
        default: st_q <= S_IDLE;
      endcase
      if (gdone) begin
        st_q      <= S_IDLE;
        cont_q    <= 1'b0;
        sf_left_q <= reload;
        crc_q     <= CRC_PRESET;
        if (kind_q == KIND_MSC && !grp_q && msc_len_q != 14'h0) begin
          // data group opens the very next sub-field
          grp_q     <= 1'b1;
          left_q    <= msc_len_q;
          has_crc_q <= 1'b0;
          ret_q     <= S_DATA;
          st_q      <= S_CI;
        end else if (kind_q == KIND_DL_MSG && 4'(seg_q) + 4'h1 < nseg_q) begin
          // next segment, index is number minus one
          seg_q  <= seg_q + 3'h1;
          hdr_q  <= dl_hdr(msg_tog_q, 1'b0, 4'(seg_q) + 4'h2 == nseg_q, nxt_len, {1'b0, seg_q + 3'h1});
          left_q <= 14'(nxt_len);
          rem_q  <= rem_q - 8'(nxt_len);
          ret_q  <= S_HDR;
          st_q   <= S_CI;
        end
      end
    end
  end

  // ==========================================
  // checks
  a_crc_preset: assert property (@(posedge ref_clk) disable iff (sys_rst)
    start_job |=> crc_q == CRC_PRESET) else $error("check register not preset");
  a_crc_invert: assert property (@(posedge ref_clk) disable iff (sys_rst)
    adv && st_q == S_CRC && !bi_q |=> xp_data == ~$past(crc_q[15:8])) else $error("check byte not inverted");
  a_pad_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    adv && st_q == S_PAD |=> xp_valid && xp_data == 8'h00) else $error("filler not zero");
  a_li_type: assert property (@(posedge ref_clk) disable iff (sys_rst)
    adv && st_q == S_CI && kind_q == KIND_MSC && !grp_q |=> xp_ci && xp_data[4:0] == APP_LEN_IND)
    else $error("length group type wrong");
  a_li_rsv: assert property (@(posedge ref_clk) disable iff (sys_rst)
    adv && st_q == S_HDR && kind_q == KIND_MSC && !bi_q |=> xp_data[7:6] == LI_RFA) else $error("reserved bits set");
  a_seg_size: assert property (@(posedge ref_clk) disable iff (sys_rst)
    kind_q == KIND_DL_MSG |-> left_q <= 14'(SEG_MAX_BYTES) && nseg_q <= DL_MAX_SEGS) else $error("segment too large");
  a_msg_limit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    kind_q == KIND_DL_MSG && st_q != S_IDLE |-> dl_len_q <= DL_MAX_BYTES) else $error("label too long");
  a_fl_code: assert property (@(posedge ref_clk) disable iff (sys_rst)
    kind_q == KIND_DL_MSG && st_q == S_HDR |-> hdr_q[HDR_FIRST_BIT] == (seg_q == 3'h0)
      && hdr_q[HDR_LAST_BIT] == (4'(seg_q) + 4'h1 == nseg_q)) else $error("first/last flags wrong");
  a_cmd_nodata: assert property (@(posedge ref_clk) disable iff (sys_rst)
    kind_q == KIND_DL_CMD && st_q != S_IDLE |-> st_q != S_DATA && hdr_q[HDR_CMD_BIT]) else $error("command carries data");
  a_short_frame: assert property (@(posedge ref_clk) disable iff (sys_rst)
    start_job && short_mode ##1 (st_q == S_CI) |-> sf_left_q == SHORT_SF_BYTES) else $error("short sub-field size wrong");
endmodule

// [rtl/xdgf_pkg.sv]
// Purpose: shared constants and types of the data group framer
// Assumes: one 100 MHz clock, byte-wide streams
// Notes:   offsets and fields are bit positions inside group words

package xdgf_pkg;
  // ==========================================
  // check word
  localparam logic [15:0] CRC_PRESET    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  // ==========================================
  // application types in contents indicators
  localparam logic [4:0]  APP_LEN_IND   = 5'h01;
  localparam logic [4:0]  APP_DL_START  = 5'h02;
  // ==========================================
  // label limits
  localparam logic [7:0]  DL_MAX_BYTES  = 8'h80;
  localparam logic [4:0]  SEG_MAX_BYTES = 5'h10;
  localparam logic [3:0]  DL_MAX_SEGS   = 4'h8;
  // ==========================================
  // segment header fields
  localparam int          HDR_TOG_BIT   = 15;
  localparam int          HDR_FIRST_BIT = 14;
  localparam int          HDR_LAST_BIT  = 13;
  localparam int          HDR_CMD_BIT   = 12;
  localparam logic [3:0]  RFA4          = 4'h0;
  localparam logic [1:0]  LI_RFA        = 2'h0;
  localparam logic [3:0]  CMD_CLEAR     = 4'h1;
  // ==========================================
  // sub-field and buffer sizes
  localparam logic [5:0]  SHORT_SF_BYTES = 6'h04;
  localparam int          BYTE_W        = 8;
  localparam int          FIFO_DEPTH    = 16;

  typedef enum logic [1:0] {KIND_MSC, KIND_DL_MSG, KIND_DL_CMD} xdgf_kind_t;
  typedef enum logic [2:0] {S_IDLE, S_CI, S_HDR, S_DATA, S_CRC, S_PAD} xdgf_state_t;
endpackage

// [sim/test_xpad_data_group_framer.sv]
// Purpose: self-checking bench of the data group framer
// Assumes: sink model accepts bytes, bench feeds payload and jobs
// Notes:   expected streams built from group layout and sub-field sizes

`timescale 1ns/100ps

module test_xpad_data_group_framer
  import xdgf_pkg::*;
  ;
  typedef logic [7:0] xdgf_byte_q_t[$];

  logic       ref_clk, sys_rst, in_valid, in_ready, req_valid, req_ready;
  logic       req_repeat, short_mode, xp_valid, xp_ready, xp_ci, xp_sf_last, busy, stall_en;
  logic [7:0] in_data, xp_data;
  logic [13:0] req_len;
  logic [4:0] application_type_code;
  logic [3:0] req_charset, req_cmd;
  logic [2:0] sf_len_code;
  xdgf_kind_t req_kind;
  logic [9:0] exp_q[$];
  logic [7:0] pay[$];
  logic       msg_tog, cmd_tog;
  int         fail_count, comparisons, len;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  xdgf_framer i_xdgf_framer (.ref_clk(ref_clk), .sys_rst(sys_rst), .in_data(in_data), .in_valid(in_valid),
    .in_ready(in_ready), .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_len(req_len),
    .application_type_code(application_type_code), .req_charset(req_charset), .req_cmd(req_cmd),
    .req_repeat(req_repeat), .short_mode(short_mode), .sf_len_code(sf_len_code), .xp_data(xp_data),
    .xp_valid(xp_valid), .xp_ready(xp_ready), .xp_ci(xp_ci), .xp_sf_last(xp_sf_last), .busy(busy));

  xdgf_sink i_xdgf_sink (.clk(ref_clk), .rst(sys_rst), .stall_en(stall_en), .data(xp_data), .valid(xp_valid),
    .ci(xp_ci), .sf_last(xp_sf_last), .ready(xp_ready));

  // ==========================================
  // expectations
  // check word model
  function automatic logic [15:0] crc_inv(xdgf_byte_q_t g);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (g[i]) for (int b = 7; b >= 0; b--) c = {c[14:0], 1'b0} ^ ((c[15] ^ g[i][b]) ? 16'h1021 : 16'h0000);
    return ~c;
  endfunction

  function automatic int sf_bytes(logic [2:0] code);
    int t[8] = '{4, 6, 8, 12, 16, 24, 32, 48};
    return t[code];
  endfunction

  // one group spread over sub-fields, zero padded at the end
  task automatic frame(input logic [4:0] a, input logic sm, input logic [2:0] code, input xdgf_byte_q_t g,
                       input bit with_crc);
    logic [15:0] c;
    int i, n;
    c = crc_inv(g);
    if (with_crc) begin
      g.push_back(c[15:8]);
      g.push_back(c[7:0]);
    end
    i = 0;
    while (i < g.size()) begin
      if (!sm || i == 0) exp_q.push_back({2'b10, sm ? 3'h0 : code, i == 0 ? a : a + 5'h01});
      n = sm ? (i == 0 ? 3 : 4) : sf_bytes(code);
      for (int k = 0; k < n; k++) begin
        exp_q.push_back({1'b0, k == n - 1, i < g.size() ? g[i] : 8'h00});
        i++;
      end
    end
  endtask

  // ==========================================
  // drivers and comparisons
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic fill(input int n);
    pay.delete();
    repeat (n) pay.push_back(8'($urandom));
  endtask

  task automatic feed(input int n);
    for (int j = 0; j < n; j++) begin
      in_data = pay[j];
      in_valid = 1'b1;
      do @(posedge ref_clk); while (in_ready !== 1'b1);
      #1;
    end
    in_valid = 1'b0;
  endtask

  task automatic run_job(input xdgf_kind_t k, input int n, input logic [4:0] a, input logic rep, input logic sm,
                         input logic [2:0] code, input int nfeed);
    int w;
    fork
      feed(nfeed);
      begin
        req_kind = k;
        req_len = 14'(n);
        application_type_code = a;
        req_repeat = rep;
        short_mode = sm;
        sf_len_code = code;
        req_valid = 1'b1;
        do @(posedge ref_clk); while (req_ready !== 1'b1);
        #1 req_valid = 1'b0;
      end
    join
    w = 0;
    repeat (3) @(posedge ref_clk);
    while (busy !== 1'b0 && w < 3000) begin
      @(posedge ref_clk);
      w++;
    end
    check("job done", 1'b0, w == 3000);
    #1;
  endtask

  task automatic check_stream(input string name);
    check({name, " count"}, exp_q.size(), i_xdgf_sink.got_q.size());
    foreach (exp_q[i]) if (i < i_xdgf_sink.got_q.size()) check(name, exp_q[i], i_xdgf_sink.got_q[i]);
    exp_q.delete();
    i_xdgf_sink.got_q.delete();
    $display("test %s done", name);
  endtask

  task automatic msc(input string name, input int n, input logic [4:0] a, input logic sm, input logic [2:0] code,
                     input int nfeed);
    logic [13:0] l;
    l = 14'(n);
    frame(5'h01, sm, code, '{{2'b00, l[13:8]}, l[7:0]}, 1);
    frame(a, sm, code, pay[0:n-1], 0);
    run_job(KIND_MSC, n, a, 1'b0, sm, code, nfeed);
    check_stream(name);
  endtask

  task automatic dl_msg(input string name, input int n, input logic rep, input logic sm, input logic [2:0] code,
                        input int nfeed);
    int m, c;
    xdgf_byte_q_t g;
    m = n > 128 ? 128 : n;
    if (!rep) msg_tog = ~msg_tog;
    req_charset = 4'($urandom);
    for (int s = 0; s * 16 < m; s++) begin
      c = m - s * 16 > 16 ? 16 : m - s * 16;
      g = pay[s * 16 : s * 16 + c - 1];
      g.push_front({s == 0 ? req_charset : {1'b0, 3'(s)}, 4'h0});
      g.push_front({msg_tog, s == 0, s * 16 + c == m, 1'b0, 4'(c - 1)});
      frame(5'h02, sm, code, g, 1);
    end
    run_job(KIND_DL_MSG, n, 5'h02, rep, sm, code, nfeed);
    check_stream(name);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================
  // tests
  initial begin
    {sys_rst, in_valid, req_valid, req_repeat, short_mode, stall_en} = 6'h21;
    {in_data, req_len, application_type_code, req_charset, req_cmd, sf_len_code} = '0;
    req_kind = KIND_MSC;
    {msg_tog, cmd_tog} = 2'h0;
    fail_count = 0;
    comparisons = 0;
    void'($urandom(51));
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    pay = '{8'hA1, 8'h5C, 8'h3E};
    msc("msc_walk", 3, 5'h04, 1'b0, 3'h0, 3);
    fill(5);
    msc("msc_short", 5, 5'h06, 1'b1, 3'h0, 5);
    // fill the buffer until it refuses, then drain it under stalls
    fill(16);
    stall_en = 1'b1;
    feed(16);
    check("fifo full", 1'b0, in_ready);
    msc("msc_full", 16, 5'h08, 1'b0, 3'h2, 0);
    check("fifo empty", 1'b1, in_ready);
    for (int r = 0; r < 6; r++) begin
      len = $urandom_range(1, 16);
      fill(len);
      msc("msc_rand", len, 5'(4 + 2 * $urandom_range(0, 3)), 1'($urandom), 3'($urandom), len);
    end
    fill(20);
    dl_msg("dl_two", 20, 1'b0, 1'b0, 3'h5, 20);
    dl_msg("dl_repeat", 20, 1'b1, 1'b1, 3'h0, 20);
    fill(128);
    dl_msg("dl_clamp", 130, 1'b0, 1'b0, 3'h4, 128);
    cmd_tog = ~cmd_tog;
    req_cmd = 4'h1;
    frame(5'h02, 1'b0, 3'h0, '{{cmd_tog, 3'b111, 4'h1}, 8'h00}, 1);
    run_job(KIND_DL_CMD, 0, 5'h02, 1'b0, 1'b0, 3'h0, 0);
    check_stream("dl_clear");
    fill(7);
    dl_msg("dl_sole", 7, 1'b0, 1'b0, 3'h1, 7);
    run_job(xdgf_kind_t'(2'h3), 0, 5'h04, 1'b0, 1'b0, 3'h0, 0);
    check_stream("kind_drop");
    final_report;
  end

  // cut a hang well past the longest expected run
  initial begin
    #(80000 * 10);
    fail_count++;
    final_report;
  end
endmodule

// [sim/xdgf_sink.sv]
// Purpose: stand-in for the frame multiplexer that takes framer bytes
// Assumes: byte handshake on ref_clk, ready may drop in any cycle
// Notes:   records {ci, sf_last, data} of every byte taken

`timescale 1ns/100ps

module xdgf_sink (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       stall_en,
  input  wire logic [7:0] data,
  input  wire logic       valid,
  input  wire logic       ci,
  input  wire logic       sf_last,
  output logic            ready
);
  logic [9:0] got_q[$];

  // ==========================================
  // accept side
  initial ready = 1'b0;
  // random stalls probe that outputs stand until taken
  always @(posedge clk) begin
    if (!rst && valid && ready) got_q.push_back({ci, sf_last, data});
    #1;
    ready <= rst ? 1'b0 : (stall_en ? ($urandom_range(0, 2) != 0) : 1'b1);
  end
endmodule
